// >>> rtl/dpam_defines.vh
// Function
// - writes into the extended data window finish in one cycle, no overhead.
// - indirect addresses below 0x8000 ignore both page registers.
// - window address with page 0x000 raises an address error trap.
// - window address is page bits 8:0 above effective address bits 14:0.
// - near data 0x0000 to 0x1FFF is also reachable by direct addressing.
// - stack pointer points at next free word; stack grows upward.
// - pop pre-decrements the stack pointer; push post-increments it.
// - call pushes program counter with its top byte zeroed.
// - exception push places status low byte over program counter top byte.
// - stack limit is not reset and every write to it clears its bit 0.
// - only push stack addresses are compared against the limit; pops and stack references are not.
// - push at pointer equal to limit is fine; the next push traps.
// - stack pointer below 0x0800 raises a stack error trap.
// - table address is table page above the 16-bit effective address.
// - table page bit 7 selects user or configuration memory.
// - read page bit 9 set forms a 23-bit program address.
// - read page bit 8 selects lower or upper program word.
// - program visibility reaches user memory only; address bit 23 is zero.
// - program address bit 15 comes from read page bit 0.
// - program visibility is read only; writes are not performed.
`ifndef DPAM_DEFINES_VH
`define DPAM_DEFINES_VH
`define DPAM_WINDOW_BIT   15
`define DPAM_PV_BIT       9
`define DPAM_PV_HI_BIT    8
`define DPAM_CFG_BIT      7
`define DPAM_NEAR_TOP     16'h1FFF
`define DPAM_SFR_END      16'h0800
`define DPAM_WORD_STEP    16'h0002
`define DPAM_RPAGE_RST    10'h001
`define DPAM_WPAGE_RST    9'h001
`define DPAM_TPAGE_RST    8'h00
`define DPAM_SP_RST       16'h0800
`endif

// >>> rtl/dpam_page_map.v
`timescale 1ns/10ps
`include "dpam_defines.vh"
module dpam_page_map #(
	parameter PW = 9
)(
	input  wire [15:0]   i_ea,
	input  wire [PW-1:0] i_page,
	output wire          o_window,
	output wire          o_page_zero,
	output wire [23:0]   o_addr
);
	assign o_window    = i_ea[`DPAM_WINDOW_BIT];
	assign o_page_zero = (i_page == {PW{1'b0}});
	// below the window the page is ignored
	assign o_addr = o_window ? {i_page[8:0], i_ea[14:0]} : {8'h00, i_ea};
endmodule // dpam_page_map

// >>> rtl/dpam_stack_check.v
`timescale 1ns/10ps
`include "dpam_defines.vh"
module dpam_stack_check (
	input  wire [15:0] i_sp,
	input  wire [15:0] i_limit,
	input  wire        i_push,
	input  wire        i_use,
	output wire        o_err
);
	// limit may hold stale power-up contents; software must load it
	wire over  = i_push && (i_sp > i_limit);
	wire under = i_sp < `DPAM_SFR_END;
	assign o_err = i_use && (over || under);
endmodule // dpam_stack_check

// >>> rtl/dpam_addr_map.v
`timescale 1ns/10ps
`include "dpam_defines.vh"
module dpam_addr_map (
	input  wire        i_ref_clk,
	input  wire        i_rst_n,
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire        i_direct,
	input  wire [15:0] i_ea,
	input  wire        i_tbl,
	input  wire        i_rpage_we,
	input  wire [9:0]  i_rpage_wdata,
	input  wire        i_wpage_we,
	input  wire [8:0]  i_wpage_wdata,
	input  wire        i_tpage_we,
	input  wire [7:0]  i_tpage_wdata,
	input  wire        i_limit_we,
	input  wire [15:0] i_limit_wdata,
	input  wire        i_sp_we,
	input  wire [15:0] i_sp_wdata,
	input  wire        i_push,
	input  wire        i_pop,
	input  wire        i_sp_ref,
	input  wire        i_call_push,
	input  wire        i_exc_push,
	input  wire [22:0] i_pc,
	input  wire [7:0]  i_status_low_byte,
	output reg  [23:0] o_data_addr,
	output reg         o_data_rd,
	output reg         o_data_wr,
	output reg  [23:0] o_prog_addr,
	output reg         o_prog_rd,
	output reg         o_prog_hi_word,
	output reg         o_cfg_space,
	output reg  [15:0] o_stack_addr,
	output reg         o_stack_rd,
	output reg         o_stack_wr,
	output reg  [15:0] o_stack_lo_word,
	output reg  [15:0] o_stack_hi_word,
	output reg  [15:0] o_stack_pointer_reg,
	output reg  [9:0]  o_data_read_page,
	output reg  [8:0]  o_data_write_page,
	output reg  [7:0]  o_table_page,
	output reg  [15:0] o_stack_limit,
	output reg         o_addr_err,
	output reg         o_stack_err
);
////////////////////////////////////////////////////////////////////////
	reg  [9:0]  data_read_page;
	reg  [8:0]  data_write_page;
	reg  [7:0]  table_page;
	reg  [15:0] stack_limit;
	reg  [15:0] stack_pointer_reg;
	wire        rwin;
	wire        rzero;
	wire [23:0] raddr;
	wire        wwin;
	wire        wzero;
	wire [23:0] waddr;
	wire        serr;
	wire        any_push;
	wire        prog_vis;
	wire [15:0] pop_sp;
	wire [15:0] access_sp;
	dpam_page_map #(.PW(10)) u_rmap (
		.i_ea        (i_ea),
		.i_page      (data_read_page),
		.o_window    (rwin),
		.o_page_zero (rzero),
		.o_addr      (raddr)
	);
	dpam_page_map #(.PW(9)) u_wmap (
		.i_ea        (i_ea),
		.i_page      (data_write_page),
		.o_window    (wwin),
		.o_page_zero (wzero),
		.o_addr      (waddr)
	);
	assign any_push  = i_push | i_call_push | i_exc_push;
	assign pop_sp    = stack_pointer_reg - `DPAM_WORD_STEP;
	assign access_sp = i_pop ? pop_sp : stack_pointer_reg;
	dpam_stack_check u_chk (
		.i_sp    (access_sp),
		.i_limit (stack_limit),
		.i_push  (any_push),
		.i_use   (any_push | i_pop | i_sp_ref),
		.o_err   (serr)
	);
	assign prog_vis = i_rd && rwin && data_read_page[`DPAM_PV_BIT];
////////////////////////////////////////////////////////////////////////
	// page and limit registers; limit has no reset
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			data_read_page  <= `DPAM_RPAGE_RST;
			data_write_page <= `DPAM_WPAGE_RST;
			table_page      <= `DPAM_TPAGE_RST;
		end
		else
		begin
			if (i_rpage_we)
				data_read_page <= i_rpage_wdata;
			if (i_wpage_we)
				data_write_page <= i_wpage_wdata;
			if (i_tpage_we)
				table_page <= i_tpage_wdata;
		end
	end
	always @(posedge i_ref_clk)
	begin
		if (i_limit_we)
			stack_limit <= {i_limit_wdata[15:1], 1'b0};
	end
////////////////////////////////////////////////////////////////////////
	// stack pointer always names the next free word
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			stack_pointer_reg <= `DPAM_SP_RST;
			o_stack_addr      <= 16'h0000;
			o_stack_rd        <= 1'b0;
			o_stack_wr        <= 1'b0;
			o_stack_lo_word   <= 16'h0000;
			o_stack_hi_word   <= 16'h0000;
			o_stack_err       <= 1'b0;
		end
		else
		begin
			o_stack_rd  <= i_pop;
			o_stack_wr  <= any_push;
			o_stack_err <= serr;
			o_stack_addr <= access_sp;
			if (i_call_push)
			begin
				// two words are pushed; this block emits both at once
				o_stack_lo_word <= i_pc[15:0];
				o_stack_hi_word <= {8'h00, 1'b0, i_pc[22:16]};
			end
			else if (i_exc_push)
			begin
				o_stack_lo_word <= i_pc[15:0];
				o_stack_hi_word <= {i_status_low_byte, 1'b0, i_pc[22:16]};
			end
			if (i_sp_we)
				stack_pointer_reg <= {i_sp_wdata[15:1], 1'b0};
			else if (i_pop)
				stack_pointer_reg <= pop_sp;
			else if (i_call_push || i_exc_push)
				stack_pointer_reg <= stack_pointer_reg + 16'h0004;
			else if (i_push)
				stack_pointer_reg <= stack_pointer_reg + `DPAM_WORD_STEP;
		end
	end
////////////////////////////////////////////////////////////////////////
	// data and program address generation, one cycle each
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_data_addr    <= 24'h000000;
			o_data_rd      <= 1'b0;
			o_data_wr      <= 1'b0;
			o_prog_addr    <= 24'h000000;
			o_prog_rd      <= 1'b0;
			o_prog_hi_word <= 1'b0;
			o_cfg_space    <= 1'b0;
			o_addr_err     <= 1'b0;
		end
		else
		begin
			o_data_rd  <= 1'b0;
			o_data_wr  <= 1'b0;
			o_prog_rd  <= 1'b0;
			o_addr_err <= 1'b0;
			if (i_tbl && (i_rd || i_wr))
			begin
				o_prog_addr <= {table_page, i_ea};
				o_cfg_space <= table_page[`DPAM_CFG_BIT];
				o_prog_rd   <= i_rd;
			end
			else if (i_direct && (i_rd || i_wr))
			begin
				o_data_addr <= {8'h00, 3'b000, i_ea[12:0]};
				o_data_rd   <= i_rd;
				o_data_wr   <= i_wr;
			end
			else if (prog_vis)
			begin
				o_prog_addr <= {1'b0, data_read_page[7:1], data_read_page[0],
					i_ea[14:0]};
				o_prog_hi_word <= data_read_page[`DPAM_PV_HI_BIT];
				o_cfg_space    <= 1'b0;
				o_prog_rd      <= 1'b1;
			end
			else if (i_rd)
			begin
				o_data_addr <= raddr;
				o_data_rd   <= ~(rwin & rzero);
				o_addr_err  <= rwin & rzero;
			end
			else if (i_wr)
			begin
				// single cycle, page bit 9 never diverts writes to program
				o_data_addr <= waddr;
				o_data_wr   <= ~(wwin & wzero);
				o_addr_err  <= wwin & wzero;
			end
		end
	end
////////////////////////////////////////////////////////////////////////
	always @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_stack_pointer_reg <= `DPAM_SP_RST;
			o_data_read_page    <= `DPAM_RPAGE_RST;
			o_data_write_page   <= `DPAM_WPAGE_RST;
			o_table_page        <= `DPAM_TPAGE_RST;
			o_stack_limit       <= 16'h0000;
		end
		else
		begin
			o_stack_pointer_reg <= stack_pointer_reg;
			o_data_read_page    <= data_read_page;
			o_data_write_page   <= data_write_page;
			o_table_page        <= table_page;
			o_stack_limit       <= stack_limit;
		end
	end
endmodule // dpam_addr_map

// >>> tb/dpam_addr_map_asserts.sv
`timescale 1ns/10ps
module dpam_chk (
	input wire        i_ref_clk, i_rst_n, i_rd, i_wr, i_direct, i_tbl, i_sp_we,
	input wire        i_push, i_pop, i_call_push, i_exc_push,
	input wire [15:0] i_ea,
	input wire [22:0] i_pc,
	input wire [7:0]  i_status_low_byte,
	input wire [23:0] o_data_addr, o_prog_addr,
	input wire        o_data_rd, o_data_wr, o_prog_rd, o_cfg_space, o_stack_rd, o_stack_wr,
	input wire        o_addr_err, o_stack_err,
	input wire [15:0] o_stack_addr, o_stack_lo_word, o_stack_hi_word,
	input wire [15:0] o_stack_pointer_reg, o_stack_limit
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////
	// priority: sp write > pop > pc push > push
	wire        dat  = !i_tbl && !i_direct;
	wire        push = i_push && !i_pop && !i_sp_we && !i_call_push && !i_exc_push;
	wire        pop  = i_pop && !i_sp_we;
	wire        pcok = !i_pop && !i_sp_we;
	wire [15:0] pclo = i_pc[15:0];
	wire [6:0]  pchi = i_pc[22:16];
	sequence s_push; push ##1 o_stack_wr; endsequence
	sequence s_pop; pop ##1 o_stack_rd; endsequence
	property p_wr_one; i_wr && !i_rd && dat |=> o_data_wr ^ o_addr_err; endproperty
	a_wr_one: assert property (p_wr_one) else $error("write late");
	property p_low; i_rd && dat && !i_ea[15] |=> o_data_rd && o_data_addr == {8'h00, $past(i_ea)};
	endproperty
	a_low: assert property (p_low) else $error("low read mapped");
	property p_tbl; i_tbl && i_rd |=> o_prog_rd && o_prog_addr[15:0] == $past(i_ea)
		&& o_cfg_space == o_prog_addr[23]; endproperty
	a_tbl: assert property (p_tbl) else $error("table address");
	property p_push; s_push |=> o_stack_pointer_reg == $past(o_stack_addr) + 16'h0002; endproperty
	a_push: assert property (p_push) else $error("push step");
	property p_pop; s_pop |=> o_stack_pointer_reg == $past(o_stack_addr); endproperty
	a_pop: assert property (p_pop) else $error("pop step");
	property p_call; i_call_push && pcok |=> o_stack_hi_word[15:8] == 8'h00
		&& o_stack_lo_word == $past(pclo); endproperty
	a_call: assert property (p_call) else $error("call push words");
	property p_exc; i_exc_push && !i_call_push && pcok |=> o_stack_hi_word ==
		{$past(i_status_low_byte), 1'b0, $past(pchi)}; endproperty
	a_exc: assert property (p_exc) else $error("exception push word");
	property p_under; s_pop ##0 (pop && o_stack_addr < 16'h0802) |=> o_stack_err; endproperty
	a_under: assert property (p_under) else $error("no underflow trap");
	property p_over; s_push ##0 (push && o_stack_addr == o_stack_limit) |=> o_stack_err;
	endproperty
	a_over: assert property (p_over) else $error("no overflow trap");
endmodule // dpam_chk
bind dpam_addr_map dpam_chk chk_u (.*);

// >>> tb/dpam_cpu_model.sv
`timescale 1ns/10ps
// cpu side: counts the traps it would vector on
module dpam_cpu_model (
	input  wire        i_ref_clk,
	input  wire        i_rst_n,
	input  wire        i_addr_err,
	input  wire        i_stack_err,
	output logic [7:0] o_traps
);
	always @(posedge i_ref_clk or negedge i_rst_n)
		if (!i_rst_n)
			o_traps <= 8'h00;
		else
			o_traps <= o_traps + {7'h00, i_addr_err} + {7'h00, i_stack_err};
endmodule // dpam_cpu_model

// >>> tb/dpam_addr_map_tb.sv
`timescale 1ns/10ps
module dpam_addr_map_tb;
	logic        i_ref_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_rd, i_wr, i_direct, i_tbl, i_rpage_we, i_wpage_we, i_tpage_we, i_limit_we;
	logic        i_sp_we, i_push, i_pop, i_sp_ref, i_call_push, i_exc_push;
	logic [15:0] i_ea, i_limit_wdata, i_sp_wdata, o_stack_addr, o_stack_lo_word;
	logic [15:0] o_stack_hi_word, o_stack_pointer_reg, o_stack_limit;
	logic [9:0]  i_rpage_wdata, o_data_read_page;
	logic [8:0]  i_wpage_wdata, o_data_write_page;
	logic [7:0]  i_tpage_wdata, i_status_low_byte, o_table_page, traps;
	logic [22:0] i_pc;
	logic [23:0] o_data_addr, o_prog_addr;
	logic        o_data_rd, o_data_wr, o_prog_rd, o_prog_hi_word, o_cfg_space, o_stack_rd;
	logic        o_stack_wr, o_addr_err, o_stack_err;
	integer      error_cnt = 0;
	integer      num_checks = 0;
	dpam_addr_map dut_u (.*);
	dpam_cpu_model cpu_u (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr_err(o_addr_err),
		.i_stack_err(o_stack_err), .o_traps(traps));
	always #10 i_ref_clk = ~i_ref_clk;
	////////////////////////
	task chk(input [31:0] seen, input [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task clr;
		{i_rd, i_wr, i_direct, i_tbl, i_rpage_we, i_wpage_we, i_tpage_we, i_limit_we} <= 8'h00;
		{i_sp_we, i_push, i_pop, i_sp_ref, i_call_push, i_exc_push} <= 6'h00;
	endtask
	task step;
		@(posedge i_ref_clk);
		clr();
		#1;
	endtask
	task setup(input [9:0] r, input [8:0] w, input [7:0] t, input [15:0] sp, input [15:0] lim);
		@(posedge i_ref_clk);
		{i_rpage_we, i_wpage_we, i_tpage_we, i_sp_we, i_limit_we} <= 5'h1F;
		{i_rpage_wdata, i_wpage_wdata, i_tpage_wdata} <= {r, w, t};
		{i_sp_wdata, i_limit_wdata} <= {sp, lim};
		step();
	endtask
	// single moves only, no read-modify-write
	task acc(input [4:0] kind, input [15:0] ea);
		@(posedge i_ref_clk);
		{i_sp_ref, i_tbl, i_direct, i_wr, i_rd} <= kind;
		i_ea <= ea;
		step();
	endtask
	task pcpush(input call);
		@(posedge i_ref_clk);
		{i_call_push, i_exc_push} <= {call, !call};
		step();
	endtask
	task burst(input integer n, input up, input [15:0] a);
		integer k;
		@(posedge i_ref_clk);
		{i_push, i_pop} <= {up, !up};
		for (k = 0; k < n; k++)
		begin
			@(posedge i_ref_clk);
			if (k == n - 1)
				clr();
			#1;
			chk(o_stack_addr, up ? a + 16'(2 * k) : a - 16'(2 * k));
			chk(o_stack_err, k == n - 1);
			chk(up ? o_stack_wr : o_stack_rd, 1'b1);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// run needs about 50 cycles; 5000 is ample
	initial
	begin
		#100000;
		error_cnt++;
		complete_run();
	end
	initial
	begin
		clr();
		{i_ea, i_rpage_wdata, i_wpage_wdata, i_tpage_wdata, i_sp_wdata, i_limit_wdata} <= '0;
		{i_pc, i_status_low_byte} <= {23'h7F1234, 8'hA5};
		repeat (12) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		step();
		chk(o_stack_pointer_reg, 16'h0800);
		setup(10'h000, 9'h1FF, 8'h81, 16'h0802, 16'h0805);
		acc(5'h01, 16'h1234);
		chk(o_data_addr, 24'h001234);
		chk({o_data_read_page, o_data_write_page, o_table_page}, 27'h00001FF81);
		acc(5'h01, 16'h8800);
		chk({o_addr_err, o_data_rd}, 2'b10);
		acc(5'h02, 16'hFFFE);
		chk(o_data_addr, 24'hFFFFFE);
		chk(o_data_wr, 1'b1);
		acc(5'h05, 16'h1FFF);
		chk(o_data_addr, 24'h001FFF);
		acc(5'h09, 16'h1234);
		chk(o_prog_addr, 24'h811234);
		chk(o_cfg_space, 1'b1);
		chk(o_stack_limit, 16'h0804);
		burst(3, 1'b1, 16'h0802);
		setup(10'h3A5, 9'h1FF, 8'h01, 16'h0802, 16'h0A00);
		burst(2, 1'b0, 16'h0800);
		acc(5'h01, 16'h800A);
		chk(o_prog_addr, 24'h52800A);
		chk(o_prog_hi_word, 1'b1);
		acc(5'h02, 16'h800A);
		chk({o_prog_rd, o_data_addr}, 25'h0FF800A);
		acc(5'h09, 16'h1234);
		chk(o_cfg_space, 1'b0);
		setup(10'h001, 9'h001, 8'h00, 16'h0900, 16'h0A00);
		pcpush(1'b1);
		chk({o_stack_hi_word, o_stack_lo_word[7:0]}, 24'h007F34);
		pcpush(1'b0);
		chk(o_stack_hi_word, 16'hA57F);
		setup(10'h001, 9'h001, 8'h00, 16'h0700, 16'h0A00);
		acc(5'h10, 16'h0700);
		chk(o_stack_err, 1'b1);
		step();
		chk(traps, 8'h04);
		complete_run();
	end
endmodule // dpam_addr_map_tb
